// File: hdl/vbi_pkg.sv
// Purpose: Shared constants for the video buffer serial control link
// Assumes: pclk at 25 MHz; single-byte register protocol
// Notes:   Address prefix value is arbitrary, not a real part code
`default_nettype none
package vbi_pkg;
	// ----------------------------------------------------------------
	// Slave address and register selection
	// ----------------------------------------------------------------
	localparam logic [4:0] DEV_ADDR_PREFIX = 5'h12; // Arbitrary value
	localparam logic [7:0] SUB_CH1         = 8'h01;
	localparam logic [7:0] SUB_CH2         = 8'h02;
	localparam logic [7:0] SUB_CH3         = 8'h03;
	localparam logic [7:0] SUB_SYNC        = 8'h04;
	localparam int         NUM_CH          = 3;
	// ----------------------------------------------------------------
	// Sync and global gate register fields
	// ----------------------------------------------------------------
	localparam int         SYNC_EN_BIT     = 0;
	localparam int         HSEL_LSB        = 1;
	localparam int         VSEL_LSB        = 3;
	localparam int         BUF_GATE_BIT    = 5;
	localparam int         MON_GATE_BIT    = 6;
	localparam logic [1:0] MUX_A           = 2'h0;
	localparam logic [1:0] MUX_B           = 2'h1;
	localparam logic [2:0] MODE_OFF        = 3'h0;
	localparam logic [2:0] MODE_MUTE       = 3'h1;
	// ----------------------------------------------------------------
	// Values after power-up, chosen by the strap level
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_RST_LO       = 8'h00;
	localparam logic [7:0] CH_RST_HI       = 8'h04; // ac-bias, both paths on per channel
	localparam logic [7:0] SYNC_RST_LO     = 8'h00;
	localparam logic [7:0] SYNC_RST_HI     = 8'h40; // Monitors on, buffers off
	localparam logic [1:0] STRAP_SYNC_CYC  = 2'h2;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         CLK_NS          = 40;
	localparam int         SCL_PERIOD_NS   = 640;
	localparam logic [3:0] QUARTER_CYC     = 4'(SCL_PERIOD_NS / CLK_NS / 4);
	// ----------------------------------------------------------------
	// Controller registers on APB
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD         = 8'h00;
	localparam logic [7:0] REG_STATUS      = 8'h04;
	localparam logic [7:0] REG_RDATA       = 8'h08;
	localparam int         CMD_DATA_LSB    = 0;
	localparam int         CMD_SUB_LSB     = 8;
	localparam int         CMD_READ_BIT    = 16;
	localparam int         CMD_SEL_LSB     = 17;
	localparam int         ST_BUSY_BIT     = 0;
	localparam int         ST_NACK_BIT     = 1;
endpackage
`default_nettype wire

// File: hdl/vbi_link_if.sv
// Purpose: Two-wire link between controller and video buffer control
// Assumes: Both lines open drain with pull-ups
// Notes:   An enable high pulls the line to the driven (low) level
`timescale 1ns/10ps
`default_nettype none
interface vbi_link_if;
	logic scl_oe;
	logic scl_o;
	logic host_sda_oe;
	logic host_sda_o;
	logic dev_sda_oe;
	logic dev_sda_o;
	logic scl;
	logic sda;

	// Wired-AND of every enabled driver over the pull-up
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (output scl_oe, scl_o, host_sda_oe, host_sda_o, input scl, sda);
	modport dev  (output dev_sda_oe, dev_sda_o, input scl, sda);
endinterface
`default_nettype wire

// File: hdl/vbi_dev.sv
// Purpose: Serial-bus slave and sync/global gate control of the video buffer
// Assumes: scl, sda, address selects and strap are asynchronous pins
// Notes:   Lines sampled by pclk; link must be much slower than pclk
`timescale 1ns/10ps
`default_nettype none
module vbi_dev
	import vbi_pkg::*;
(
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// Serial link
	vbi_link_if.dev                     bus,
	// Pins
	input  wire logic                   slave_addr_select_hi,
	input  wire logic                   slave_addr_select_lo,
	input  wire logic                   power_up_state_strap,
	// Configuration towards the analog channels
	output logic [NUM_CH-1:0][7:0]      chan_cfg,
	output logic [NUM_CH-1:0]           monitor_en,
	output logic [NUM_CH-1:0]           buffer_en,
	output logic                        sync_paths_en,
	output logic [1:0]                  hsync_mux_sel,
	output logic [1:0]                  vsync_mux_sel
);
	typedef enum logic [3:0] {
		D_IDLE, D_ADDR, D_ADDR_ACK, D_SUB, D_SUB_ACK,
		D_WDATA, D_WDATA_ACK, D_RDATA, D_RACK, D_WAIT
	} vbi_dstate_t;

	vbi_dstate_t            state_r;
	logic [2:0]             scl_s_r;
	logic [2:0]             sda_s_r;
	logic [1:0]             sel_s1_r;
	logic [1:0]             sel_s2_r;
	logic [1:0]             strap_s_r;
	logic [1:0]             init_cnt_r;
	logic                   init_done_r;
	logic [3:0]             bit_cnt_r;
	logic [7:0]             shift_r;
	logic [7:0]             sub_r;
	logic                   sda_low_r;
	logic [7:0]             sync_r;
	logic [NUM_CH-1:0][7:0] chan_r;

	// Decode shared by the register write and the read mux
	function automatic logic is_chan(input logic [7:0] s);
		is_chan = (s >= SUB_CH1) && (s <= SUB_CH3);
	endfunction

	function automatic logic [7:0] rd_byte(input logic [7:0] s,
		input logic [7:0] sync, input logic [NUM_CH-1:0][7:0] ch);
		logic [1:0] idx;
		idx = 2'(s - SUB_CH1);
		if (is_chan(s)) begin
			rd_byte = ch[idx];
		end else if (s == SUB_SYNC) begin
			rd_byte = sync;
		end else begin
			rd_byte = 8'h00;
		end
	endfunction

	// Byte handed out in the read data phase
	logic [7:0] rd_val;
	assign rd_val = rd_byte(sub_r, sync_r, chan_r);

	// ----------------------------------------------------------------
	// Pin synchronisers and line events
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s_r   <= 3'h7;
			sda_s_r   <= 3'h7;
			sel_s1_r  <= 2'h0;
			sel_s2_r  <= 2'h0;
			strap_s_r <= 2'h0;
		end else begin
			scl_s_r   <= {scl_s_r[1:0], bus.scl};
			sda_s_r   <= {sda_s_r[1:0], bus.sda};
			sel_s1_r  <= {slave_addr_select_hi, slave_addr_select_lo};
			sel_s2_r  <= sel_s1_r;
			strap_s_r <= {strap_s_r[0], power_up_state_strap};
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic byte_end;
	logic wr_en;
	assign scl_rise = scl_s_r[1] & ~scl_s_r[2];
	assign scl_fall = ~scl_s_r[1] & scl_s_r[2];
	assign start_ev = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
	assign stop_ev  = scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];
	assign byte_end = scl_fall && (bit_cnt_r == 4'h8);
	assign wr_en    = (state_r == D_WDATA) && byte_end;

	// ----------------------------------------------------------------
	// Protocol engine
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= D_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
			sub_r     <= 8'h00;
			sda_low_r <= 1'b0;
		end else if (start_ev) begin
			state_r   <= D_ADDR;
			bit_cnt_r <= 4'h0;
			sda_low_r <= 1'b0;
		end else if (stop_ev) begin
			state_r   <= D_IDLE;
			sda_low_r <= 1'b0;
		end else begin
			unique case (state_r)
			D_ADDR, D_SUB, D_WDATA: begin
				if (scl_rise && bit_cnt_r < 4'h8) begin
					shift_r   <= {shift_r[6:0], sda_s_r[1]};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
				if (byte_end) begin
					bit_cnt_r <= 4'h0;
					if (state_r == D_ADDR) begin
						// Select pins compared live, never latched
						if (shift_r[7:3] == DEV_ADDR_PREFIX && shift_r[2:1] == sel_s2_r) begin
							sda_low_r <= 1'b1;
							state_r   <= D_ADDR_ACK;
						end else begin
							state_r   <= D_WAIT;
						end
					end else if (state_r == D_SUB) begin
						sub_r     <= shift_r;
						sda_low_r <= 1'b1;
						state_r   <= D_SUB_ACK;
					end else begin
						sda_low_r <= 1'b1;
						state_r   <= D_WDATA_ACK;
					end
				end
			end
			D_ADDR_ACK: begin
				if (scl_fall) begin
					bit_cnt_r <= 4'h0;
					if (shift_r[0]) begin
						shift_r   <= rd_val;
						sda_low_r <= ~rd_val[7];
						state_r   <= D_RDATA;
					end else begin
						sda_low_r <= 1'b0;
						state_r   <= D_SUB;
					end
				end
			end
			D_SUB_ACK: begin
				if (scl_fall) begin
					sda_low_r <= 1'b0;
					state_r   <= D_WDATA;
				end
			end
			D_WDATA_ACK: begin
				// Further bytes go unanswered until the next start
				if (scl_fall) begin
					sda_low_r <= 1'b0;
					state_r   <= D_WAIT;
				end
			end
			D_RDATA: begin
				if (scl_fall) begin
					bit_cnt_r <= bit_cnt_r + 4'h1;
					if (bit_cnt_r == 4'h7) begin
						sda_low_r <= 1'b0;
						state_r   <= D_RACK;
					end else begin
						shift_r   <= {shift_r[6:0], 1'b0};
						sda_low_r <= ~shift_r[6];
					end
				end
			end
			D_RACK: begin
				// Read ends after the master's acknowledge slot, whatever level it drives
				if (scl_fall) begin
					state_r <= D_WAIT;
				end
			end
			D_IDLE, D_WAIT: begin
			end
			endcase
		end
	end

	assign bus.dev_sda_oe = sda_low_r;
	assign bus.dev_sda_o  = 1'b0;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_r  <= 2'h0;
			init_done_r <= 1'b0;
			sync_r      <= SYNC_RST_LO;
			chan_r      <= '0;
		end else if (!init_done_r) begin
			// Strap is caught after it has crossed the synchroniser
			init_cnt_r <= init_cnt_r + 2'h1;
			if (init_cnt_r == STRAP_SYNC_CYC) begin
				init_done_r <= 1'b1;
				sync_r      <= strap_s_r[1] ? SYNC_RST_HI : SYNC_RST_LO;
				for (int i = 0; i < NUM_CH; i++) begin
					chan_r[i] <= strap_s_r[1] ? CH_RST_HI : CH_RST_LO;
				end
			end
		end else if (wr_en) begin
			if (is_chan(sub_r)) begin
				chan_r[2'(sub_r - SUB_CH1)] <= shift_r;
			end else if (sub_r == SUB_SYNC) begin
				sync_r <= shift_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_paths_en <= 1'b0;
			hsync_mux_sel <= MUX_A;
			vsync_mux_sel <= MUX_A;
			chan_cfg      <= '0;
		end else begin
			sync_paths_en <= sync_r[SYNC_EN_BIT];
			hsync_mux_sel <= sync_r[HSEL_LSB +: 2];
			vsync_mux_sel <= sync_r[VSEL_LSB +: 2];
			chan_cfg      <= chan_r;
		end
	end

	// Gates clear the enables in any mode; OFF and MUTE modes keep them clear with the gates set
	for (genvar g = 0; g < NUM_CH; g++) begin : g_gate
		logic path_on;
		assign path_on = (chan_r[g][2:0] != MODE_OFF) && (chan_r[g][2:0] != MODE_MUTE);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				monitor_en[g] <= 1'b0;
				buffer_en[g]  <= 1'b0;
			end else begin
				monitor_en[g] <= sync_r[MON_GATE_BIT] & path_on;
				buffer_en[g]  <= sync_r[BUF_GATE_BIT] & path_on;
			end
		end
	end
endmodule
`default_nettype wire

// File: hdl/vbi_host.sv
// Purpose: Link master issuing single-register writes and two-phase reads
// Assumes: Software orders transfers over APB
// Notes:   Drives scl itself from a divider of pclk
`timescale 1ns/10ps
`default_nettype none
module vbi_host
	import vbi_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link
	vbi_link_if.host         bus
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} vbi_hstate_t;

	vbi_hstate_t state_r;
	logic [7:0]  cmd_data_r;
	logic [7:0]  cmd_sub_r;
	logic        cmd_read_r;
	logic [1:0]  cmd_sel_r;
	logic        go_r;
	logic        busy_r;
	logic        nack_r;
	logic        nack_set;
	logic [7:0]  rdata_r;
	logic [3:0]  div_r;
	logic [1:0]  q_r;
	logic        frame_r;
	logic [1:0]  byte_r;
	logic [3:0]  bit_r;
	logic [7:0]  txb_r;
	logic [7:0]  rxb_r;
	logic        scl_low_r;
	logic        sda_low_r;
	logic [1:0]  sda_s_r;
	logic        tick;
	logic        setup;
	logic        access;
	logic        rx_byte;
	logic        last_byte;

	function automatic logic [7:0] tx_byte(input logic fr, input logic [1:0] b,
		input logic [1:0] sel, input logic [7:0] sub, input logic [7:0] dat);
		unique case (b)
			2'h0:    tx_byte = {DEV_ADDR_PREFIX, sel, fr};
			2'h1:    tx_byte = sub;
			default: tx_byte = dat;
		endcase
	endfunction

	assign setup     = psel & ~penable;
	assign access    = psel & penable & pready;
	assign rx_byte   = frame_r && (byte_r == 2'h1);
	assign last_byte = cmd_read_r ? (byte_r == 2'h1) : (byte_r == 2'h2);
	assign tick      = (div_r == QUARTER_CYC - 4'h1);

	// ----------------------------------------------------------------
	// APB register slave, no wait states
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h0000_0000;
			go_r       <= 1'b0;
			cmd_data_r <= 8'h00;
			cmd_sub_r  <= 8'h00;
			cmd_read_r <= 1'b0;
			cmd_sel_r  <= 2'h0;
			nack_r     <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~(paddr == REG_CMD || paddr == REG_STATUS || paddr == REG_RDATA);
			prdata  <= 32'h0000_0000;
			if (setup && !pwrite) begin
				if (paddr == REG_STATUS) begin
					prdata <= 32'({nack_r, busy_r | go_r});
				end else if (paddr == REG_RDATA) begin
					prdata <= 32'(rdata_r);
				end
			end
			go_r <= 1'b0;
			// A command while busy is dropped
			if (access && pwrite && paddr == REG_CMD && !busy_r && !go_r) begin
				cmd_data_r <= pwdata[CMD_DATA_LSB +: 8];
				cmd_sub_r  <= pwdata[CMD_SUB_LSB +: 8];
				cmd_read_r <= pwdata[CMD_READ_BIT];
				cmd_sel_r  <= pwdata[CMD_SEL_LSB +: 2];
				go_r       <= 1'b1;
			end
			// Set wins over a write-one clear in the same cycle
			if (nack_set) begin
				nack_r <= 1'b1;
			end else if (access && pwrite && paddr == REG_STATUS && pwdata[ST_NACK_BIT]) begin
				nack_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Link sequencer, four quarters per bit
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_s_r <= 2'h3;
			div_r   <= 4'h0;
		end else begin
			sda_s_r <= {sda_s_r[0], bus.sda};
			div_r   <= tick ? 4'h0 : div_r + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= H_IDLE;
			busy_r    <= 1'b0;
			nack_set  <= 1'b0;
			rdata_r   <= 8'h00;
			q_r       <= 2'h0;
			frame_r   <= 1'b0;
			byte_r    <= 2'h0;
			bit_r     <= 4'h0;
			txb_r     <= 8'h00;
			rxb_r     <= 8'h00;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
		end else begin
			nack_set <= 1'b0;
			if (state_r == H_IDLE) begin
				if (go_r) begin
					busy_r  <= 1'b1;
					frame_r <= 1'b0;
					q_r     <= 2'h0;
					state_r <= H_START;
				end
			end else if (tick) begin
				q_r <= q_r + 2'h1;
				unique case (state_r)
				H_START: begin
					if (q_r == 2'h0) begin
						sda_low_r <= 1'b0;
						scl_low_r <= 1'b0;
					end else if (q_r == 2'h1) begin
						sda_low_r <= 1'b1;
					end else begin
						scl_low_r <= 1'b1;
						byte_r    <= 2'h0;
						bit_r     <= 4'h0;
						txb_r     <= tx_byte(frame_r, 2'h0, cmd_sel_r, cmd_sub_r, cmd_data_r);
						q_r       <= 2'h0;
						state_r   <= H_BIT;
					end
				end
				H_BIT: begin
					if (q_r == 2'h0) begin
						// Released on acknowledge slots and while receiving
						sda_low_r <= (bit_r < 4'h8) && !rx_byte && !txb_r[7];
					end else if (q_r == 2'h1) begin
						scl_low_r <= 1'b0;
					end else if (q_r == 2'h3) begin
						scl_low_r <= 1'b1;
						if (bit_r < 4'h8) begin
							rxb_r <= {rxb_r[6:0], sda_s_r[1]};
							txb_r <= {txb_r[6:0], 1'b0};
							bit_r <= bit_r + 4'h1;
						end else if (!rx_byte && sda_s_r[1]) begin
							// Cleared so a refused read never starts its data phase
							byte_r   <= 2'h0;
							nack_set <= 1'b1;
							state_r  <= H_STOP;
						end else if (rx_byte || last_byte) begin
							if (rx_byte) begin
								rdata_r <= rxb_r;
							end
							state_r <= H_STOP;
						end else begin
							byte_r <= byte_r + 2'h1;
							bit_r  <= 4'h0;
							txb_r  <= tx_byte(frame_r, byte_r + 2'h1, cmd_sel_r, cmd_sub_r, cmd_data_r);
						end
					end
				end
				H_STOP: begin
					if (q_r == 2'h0) begin
						sda_low_r <= 1'b1;
					end else if (q_r == 2'h1) begin
						scl_low_r <= 1'b0;
					end else if (q_r == 2'h2) begin
						sda_low_r <= 1'b0;
					end else if (cmd_read_r && !frame_r && !nack_set && byte_r == 2'h1) begin
						frame_r <= 1'b1;
						q_r     <= 2'h0;
						state_r <= H_START;
					end else begin
						busy_r  <= 1'b0;
						state_r <= H_IDLE;
					end
				end
				H_IDLE: begin
				end
				endcase
			end
		end
	end

	assign bus.scl_oe      = scl_low_r;
	assign bus.scl_o       = 1'b0;
	assign bus.host_sda_oe = sda_low_r;
	assign bus.host_sda_o  = 1'b0;
endmodule
`default_nettype wire

// File: tb/vbi_checker.sv
// Purpose: Timing relations on the serial link and the gate outputs
// Assumes: Both link ends are design modules sharing pclk
// Notes:   Outputs may move freely while the strap value settles
`timescale 1ns/10ps
`default_nettype none
module vbi_checker
	import vbi_pkg::*;
(
	// Clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// Link
	input wire logic                   host_sda_oe,
	input wire logic                   dev_sda_oe,
	input wire logic                   scl,
	input wire logic                   sda,
	// Device outputs
	input wire logic [NUM_CH-1:0][7:0] chan_cfg,
	input wire logic [NUM_CH-1:0]      monitor_en,
	input wire logic [NUM_CH-1:0]      buffer_en,
	input wire logic                   sync_paths_en,
	input wire logic [1:0]             hsync_mux_sel,
	input wire logic [1:0]             vsync_mux_sel
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Cycles since reset release, to skip the strap load
	// ----------------------------------------------------------------
	logic [3:0] up_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_r <= 4'h0;
		end else if (up_r != 4'hf) begin
			up_r <= up_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_scl_low;
		$fell(scl) |-> !scl[*3] ##[1:6] scl;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl low phase length wrong");
	property p_dev_chg;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_dev_chg: assert property (p_dev_chg) else $error("device sda moved with scl high");
	property p_ack_hold;
		$rose(dev_sda_oe) |-> dev_sda_oe[*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("device low bit too short");
	property p_start_host;
		$fell(sda) && scl |-> host_sda_oe;
	endproperty
	a_start_host: assert property (p_start_host) else $error("start not made by host");
	property p_idle;
		$rose(sda) && scl |=> !dev_sda_oe[*8];
	endproperty
	a_idle: assert property (p_idle) else $error("device pulls sda after stop");
	property p_sync_low;
		$changed({sync_paths_en, hsync_mux_sel, vsync_mux_sel}) |-> !scl || up_r < 4'h8;
	endproperty
	a_sync_low: assert property (p_sync_low) else $error("sync outputs moved off write");
	property p_chan_low;
		$changed(chan_cfg) |-> !scl || up_r < 4'h8;
	endproperty
	a_chan_low: assert property (p_chan_low) else $error("channel cfg moved off write");
	property p_en_low;
		$changed({monitor_en, buffer_en}) |-> !scl || up_r < 4'h8;
	endproperty
	a_en_low: assert property (p_en_low) else $error("path enables moved off write");
	property p_mode_off;
		(chan_cfg[0][2:1] == 2'h0)[*2] |-> !monitor_en[0] && !buffer_en[0];
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("off channel path enabled");
endmodule
`default_nettype wire

// File: tb/vbi_test.sv
// Purpose: Host and device joined on one link, driven over APB
// Assumes: Strap high for the first reset, low for the second; address pins moved by the bench
// Notes:   Wire monitor keeps the first byte and ack of each frame
`timescale 1ns/10ps
`default_nettype none
module video_buffer_i2c_control_test
	import vbi_pkg::*;
;
	logic                   pclk = 1'b0, presetn = 1'b0;
	logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h0000_0000;
	logic [31:0]            prdata;
	logic                   pready, pslverr, sync_en;
	logic                   a_hi = 1'b0, a_lo = 1'b0, strap = 1'b1;
	logic [NUM_CH-1:0][7:0] chan_cfg;
	logic [NUM_CH-1:0]      mon_en, buf_en;
	logic [1:0]             hsel, vsel;
	logic                   scl_q = 1'b1, sda_q = 1'b1, first_ack = 1'b0;
	logic [7:0]             sh = 8'h00, first_b = 8'h00, q;
	int                     nb = 0, failures = 0, n_compared = 0;

	always #20 pclk = ~pclk;

	vbi_link_if lk();
	vbi_host vbi_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(lk.host));
	vbi_dev vbi_dev_i (.pclk(pclk), .presetn(presetn), .bus(lk.dev),
		.slave_addr_select_hi(a_hi), .slave_addr_select_lo(a_lo),
		.power_up_state_strap(strap), .chan_cfg(chan_cfg), .monitor_en(mon_en),
		.buffer_en(buf_en), .sync_paths_en(sync_en), .hsync_mux_sel(hsel),
		.vsync_mux_sel(vsel));
	vbi_checker vbi_checker_i (.pclk(pclk), .presetn(presetn), .host_sda_oe(lk.host_sda_oe),
		.dev_sda_oe(lk.dev_sda_oe), .scl(lk.scl), .sda(lk.sda), .chan_cfg(chan_cfg),
		.monitor_en(mon_en), .buffer_en(buf_en), .sync_paths_en(sync_en),
		.hsync_mux_sel(hsel), .vsync_mux_sel(vsel));

	// ----------------------------------------------------------------
	// Wire monitor: bits taken on scl rise, counted from each start
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		scl_q <= lk.scl;
		sda_q <= lk.sda;
		if (lk.scl && scl_q && sda_q && !lk.sda) begin
			nb = 0;
		end else if (lk.scl && !scl_q) begin
			nb = nb + 1;
			if (nb == 8) first_b = {sh[6:0], lk.sda};
			if (nb == 9) first_ack = lk.sda;
			sh = {sh[6:0], lk.sda};
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] got);
		n_compared++;
		if (got !== ex) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", n, ex, got);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic xfer(input logic [1:0] s, input logic rd, input logic [7:0] sub,
		input logic [7:0] d, output logic [7:0] v);
		logic [31:0] r;
		logic        e;
		apb(REG_CMD, 1'b1, {13'h0, s, rd, sub, d}, r, e);
		do apb(REG_STATUS, 1'b0, 32'h0, r, e); while (r[ST_BUSY_BIT] !== 1'b0);
		apb(REG_RDATA, 1'b0, 32'h0, r, e);
		v = r[7:0];
	endtask

	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		logic [7:0] v;
		xfer({a_hi, a_lo}, 1'b0, sub, d, v);
	endtask

	task automatic rd(input logic [7:0] sub, output logic [7:0] v);
		xfer({a_hi, a_lo}, 1'b1, sub, 8'h00, v);
	endtask

	task automatic nack(input logic ex);
		logic [31:0] r;
		logic        e;
		apb(REG_STATUS, 1'b0, 32'h0, r, e);
		chk("nack flag", 8'(ex), 8'(r[ST_NACK_BIT]));
	endtask

	task automatic pins(input logic [1:0] k);
		a_hi <= k[1];
		a_lo <= k[0];
		repeat (4) @(posedge pclk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_strap();
		chk("monitor_en", 8'h07, 8'(mon_en));
		chk("buffer_en", 8'h00, 8'(buf_en));
		chk("chan3", CH_RST_HI, chan_cfg[2]);
		chk("sync outs", 8'h00, {3'h0, vsel, hsel, sync_en});
		rd(SUB_SYNC, q);
		chk("sync read", SYNC_RST_HI, q);
		chk("read addr", {DEV_ADDR_PREFIX, a_hi, a_lo, 1'b1}, first_b);
	endtask

	// Every address pin setting and every select code in turn
	task automatic t_sync();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			pins(2'(i));
			v = {i[0], 2'h3, i[1:0], ~i[1:0], i[1]};
			wr(SUB_SYNC, v);
			chk("write addr", {DEV_ADDR_PREFIX, i[1:0], 1'b0}, first_b);
			chk("sync_en", 8'(v[0]), 8'(sync_en));
			chk("hsel", 8'(v[2:1]), 8'(hsel));
			chk("vsel", 8'(v[4:3]), 8'(vsel));
			chk("gates bit7", 8'h07, 8'(mon_en & buf_en));
			rd(SUB_SYNC, q);
			chk("sync back", v, q);
		end
	endtask

	task automatic t_gate();
		logic [1:0] k;
		wr(SUB_CH1, 8'h01);
		wr(SUB_CH2, 8'h02);
		wr(SUB_CH3, 8'h04);
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			wr(SUB_SYNC, {1'b0, k, 5'h00});
			chk("monitor gate", 8'(k[1] ? 3'h6 : 3'h0), 8'(mon_en));
			chk("buffer gate", 8'(k[0] ? 3'h6 : 3'h0), 8'(buf_en));
		end
		chk("chan2", 8'h02, chan_cfg[1]);
		rd(SUB_CH3, q);
		chk("chan3 read", 8'h04, q);
	endtask

	task automatic t_unknown();
		wr(8'h05, 8'hff);
		nack(1'b0);
		chk("chan1 kept", 8'h01, chan_cfg[0]);
		chk("gates kept", 8'h06, 8'(mon_en & buf_en));
		rd(8'h05, q);
		chk("unknown read", 8'h00, q);
		rd(8'h00, q);
		chk("zero read", 8'h00, q);
	endtask

	// Mismatched select is refused, then a live pin change makes it match
	task automatic t_addr();
		logic [31:0] r;
		logic        e;
		pins(2'h2);
		xfer(2'h1, 1'b0, SUB_CH1, 8'h07, q);
		nack(1'b1);
		chk("addr ack", 8'h01, 8'(first_ack));
		chk("chan1 kept", 8'h01, chan_cfg[0]);
		apb(REG_STATUS, 1'b1, 32'h0000_0002, r, e);
		pins(2'h1);
		xfer(2'h1, 1'b0, SUB_CH1, 8'h07, q);
		nack(1'b0);
		chk("chan1 new", 8'h07, chan_cfg[0]);
		apb(8'h0c, 1'b0, 32'h0, r, e);
		chk("unmapped err", 8'h01, 8'(e));
		chk("unmapped data", 8'h00, r[7:0]);
	endtask

	// Second reset with the strap low: everything comes up off
	task automatic t_strap_lo();
		strap <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		chk("monitor_en lo", 8'h00, 8'(mon_en));
		chk("buffer_en lo", 8'h00, 8'(buf_en));
		chk("chan1 lo", CH_RST_LO, chan_cfg[0]);
		rd(SUB_SYNC, q);
		chk("sync read lo", SYNC_RST_LO, q);
	endtask

	task automatic summarize();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		t_strap();
		t_sync();
		t_gate();
		t_unknown();
		t_addr();
		t_strap_lo();
		summarize();
	end

	// Whole run is about 12k cycles
	initial begin
		repeat (60000) @(posedge pclk);
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
